/* File: logic/tmw_pkg.sv */
// constants shared by the waveform timer
package tmw_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] MIN_REG_TOP = 16'h0003;
  // waveform select codes
  localparam logic [3:0] WS_NORMAL = 4'h0;
  localparam logic [3:0] WS_CTC_CMP = 4'h4;
  localparam logic [3:0] WS_FAST_8 = 4'h5;
  localparam logic [3:0] WS_FAST_9 = 4'h6;
  localparam logic [3:0] WS_FAST_10 = 4'h7;
  localparam logic [3:0] WS_CTC_CAP = 4'hC;
  localparam logic [3:0] WS_FAST_CAP = 4'hE;
  localparam logic [3:0] WS_FAST_CMP = 4'hF;
  // compare output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // prescaler: select 0 stops, 1..5 give divide by 1, 8, 64, 256, 1024
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  localparam logic [9:0] PRE_RESET = 10'h000;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
endpackage

/* File: logic/tmw_timer.sv */
// 16-bit timer: counting modes, compare output latches and pin override
//
// Notes on behaviour
// [R1] reset clears compare output latches to zero
// [R2] nonzero action field routes latch to pin
// [R3] pin direction stays with the direction bit
// [R4] action field never touches capture logic
// [R5] action zero leaves latch unchanged on match
// [R6] new action at next match; force acts now outside PWM, ignored in fast PWM
// [R7] only waveform select shapes the count
// [R8] normal mode: count up, wrap FFFF to 0
// [R9] normal overflow flag set as count hits zero
// [R10] interrupt acknowledge clears the overflow flag
// [R11] count writes accepted anytime in normal mode
// [R12] clear-on-match: clear at top from A/capture
// [R13] clear-on-match: flag of top register set at top
// [R14] top unbuffered; missed top wraps through FFFF
// [R15] clear-on-match toggle inverts latch A per match
// [R16] clear-on-match overflow set on FFFF to 0 unless top is FFFF
// [R17] fast PWM: bottom to top, then restart
// [R18] fast PWM: set action clears on match, clear action sets; reverse at top
// [R19] fast PWM top fixed, capture or compare A
// [R20] software keeps register top at least 0x0003
// [R21] fast PWM compare flag on every equal
// [R22] prescaler divides by 1, 8, 64, 256, 1024
// [R23] force updates latch only, no flag, no clear
// [R24] count write blocks matches next timer cycle
// [R25] PWM compare double buffered, loaded at top
// [R26] fast PWM overflow flag set at top
// [R27] pin mux by action field, gated by direction
`timescale 1ns/100ps
module tmw_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] clock_select,
  input wire logic [3:0] waveform_select,
  input wire logic [1:0] channel_a_output_action,
  input wire logic [1:0] channel_b_output_action,
  input wire logic force_compare_strobe_a,
  input wire logic force_compare_strobe_b,
  input wire logic count_wr,
  input wire logic [15:0] count_wdata,
  input wire logic compare_a_wr,
  input wire logic compare_b_wr,
  input wire logic [15:0] compare_wdata,
  input wire logic capture_wr,
  input wire logic [15:0] capture_wdata,
  input wire logic overflow_ack,
  input wire logic compare_a_clear,
  input wire logic compare_b_clear,
  input wire logic capture_clear,
  input wire logic port_out_a,
  input wire logic port_out_b,
  input wire logic channel_a_pin_direction_bit,
  input wire logic channel_b_pin_direction_bit,
  output logic [15:0] count_value,
  output logic overflow_flag,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic capture_flag,
  output logic channel_a_output_latch,
  output logic channel_b_output_latch,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);
  default clocking cb @(posedge core_clk);
  endclocking

  logic [9:0] prescale;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] compare_buf_a;
  logic [15:0] compare_buf_b;
  logic [15:0] capture_value;
  logic match_block;

  // prescaler mask per clock select
  function automatic logic [9:0] pre_mask(input logic [2:0] cs);
    case (cs)
      tmw_pkg::CS_DIV1: pre_mask = tmw_pkg::PRE_MASK_1;
      tmw_pkg::CS_DIV8: pre_mask = tmw_pkg::PRE_MASK_8;
      tmw_pkg::CS_DIV64: pre_mask = tmw_pkg::PRE_MASK_64;
      tmw_pkg::CS_DIV256: pre_mask = tmw_pkg::PRE_MASK_256;
      default: pre_mask = tmw_pkg::PRE_MASK_1024;
    endcase
  endfunction

  // next latch value for one channel
  function automatic logic latch_next(input logic cur, input logic [1:0] act,
                                      input logic pwm, input logic tog_ok,
                                      input logic match, input logic at_top,
                                      input logic force_now);
    logic r;
    r = cur;
    if (!pwm) begin
      if (match || force_now) begin
        case (act)
          tmw_pkg::ACT_TOGGLE: r = !cur;
          tmw_pkg::ACT_CLEAR: r = 1'b0;
          tmw_pkg::ACT_SET: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else begin
      case (act)
        tmw_pkg::ACT_TOGGLE: r = (match && tog_ok) ? !cur : cur;
        tmw_pkg::ACT_CLEAR: r = match ? 1'b1 : (at_top ? 1'b0 : cur);
        tmw_pkg::ACT_SET: r = match ? 1'b0 : (at_top ? 1'b1 : cur);
        default: r = cur;
      endcase
    end
    latch_next = r;
  endfunction

  // mode decode, from waveform select only
  wire mode_normal = (waveform_select == tmw_pkg::WS_NORMAL); // see [R7]
  wire mode_ctc_cmp = (waveform_select == tmw_pkg::WS_CTC_CMP);
  wire mode_ctc_cap = (waveform_select == tmw_pkg::WS_CTC_CAP);
  wire mode_ctc = mode_ctc_cmp || mode_ctc_cap;
  wire mode_fast_cmp = (waveform_select == tmw_pkg::WS_FAST_CMP);
  wire mode_fast_cap = (waveform_select == tmw_pkg::WS_FAST_CAP);
  wire mode_fast = (waveform_select == tmw_pkg::WS_FAST_8)
                   || (waveform_select == tmw_pkg::WS_FAST_9)
                   || (waveform_select == tmw_pkg::WS_FAST_10)
                   || mode_fast_cap || mode_fast_cmp; // see [R17]
  wire mode_pwm = mode_fast;

  // top of the count sequence
  wire [15:0] top_value =
    (waveform_select == tmw_pkg::WS_FAST_8) ? tmw_pkg::TOP_8BIT :
    (waveform_select == tmw_pkg::WS_FAST_9) ? tmw_pkg::TOP_9BIT :
    (waveform_select == tmw_pkg::WS_FAST_10) ? tmw_pkg::TOP_10BIT :
    (mode_ctc_cap || mode_fast_cap) ? capture_value :
    (mode_ctc_cmp || mode_fast_cmp) ? compare_value_a : tmw_pkg::CNT_MAX; // see [R12] [R19]

  // timer clock enable from the prescaler
  wire [9:0] mask_sel = pre_mask(clock_select);
  wire tick = (clock_select != tmw_pkg::CS_STOP)
              && ((prescale & mask_sel) == mask_sel); // see [R22]

  wire at_max = (count_value == tmw_pkg::CNT_MAX);
  wire at_top = (mode_ctc || mode_fast) && (count_value == top_value); // see [R14]
  wire top_hit = tick && at_top && !match_block;
  wire wrap = tick && at_max && !at_top;
  wire match_a = tick && !match_block && (count_value == compare_value_a); // see [R24]
  wire match_b = tick && !match_block && (count_value == compare_value_b);
  wire force_a = force_compare_strobe_a && !mode_pwm; // see [R6]
  wire force_b = force_compare_strobe_b && !mode_pwm;
  wire pwm_top = mode_fast && top_hit;

  wire [15:0] next_count =
    count_wr ? count_wdata : // see [R11]
    !tick ? count_value :
    (top_hit || wrap) ? tmw_pkg::CNT_BOTTOM : // see [R8] [R12]
    count_value + 16'h0001;

  wire set_ovf = (mode_normal || mode_ctc) ? wrap : pwm_top; // see [R9] [R16] [R26]
  wire set_cmp_a = match_a || (mode_fast_cmp && top_hit); // see [R13] [R21]
  wire set_cap = (mode_ctc_cap || mode_fast_cap) && top_hit; // see [R13]

  wire next_latch_a = latch_next(channel_a_output_latch, channel_a_output_action, mode_pwm,
                                 mode_fast_cmp, match_a && !(mode_pwm && at_top
                                 && compare_value_a != top_value), pwm_top, force_a); // see [R15] [R18]
  wire next_latch_b = latch_next(channel_b_output_latch, channel_b_output_action, mode_pwm,
                                 1'b0, match_b, pwm_top, force_b); // see [R18]

  // pin override: latch when action nonzero, else port value; direction from direction bit
  wire next_pin_a = (channel_a_output_action != tmw_pkg::ACT_NONE) ? channel_a_output_latch
                    : port_out_a; // see [R2] [R27]
  wire next_pin_b = (channel_b_output_action != tmw_pkg::ACT_NONE) ? channel_b_output_latch
                    : port_out_b; // see [R2] [R27]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescale <= tmw_pkg::PRE_RESET;
    end else if (clock_select == tmw_pkg::CS_STOP) begin
      prescale <= tmw_pkg::PRE_RESET;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_value <= tmw_pkg::CNT_RESET;
      match_block <= 1'b0;
    end else begin
      count_value <= next_count;
      match_block <= count_wr ? 1'b1 : (tick ? 1'b0 : match_block); // see [R24]
    end
  end

  // compare registers: direct in non-PWM, buffered to top in PWM
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_value_a <= tmw_pkg::CNT_RESET;
      compare_value_b <= tmw_pkg::CNT_RESET;
      compare_buf_a <= tmw_pkg::CNT_RESET;
      compare_buf_b <= tmw_pkg::CNT_RESET;
      capture_value <= tmw_pkg::CNT_RESET;
    end else begin
      if (compare_a_wr) begin
        compare_buf_a <= compare_wdata;
      end
      if (compare_b_wr) begin
        compare_buf_b <= compare_wdata;
      end
      if (!mode_pwm) begin
        compare_value_a <= compare_a_wr ? compare_wdata : compare_buf_a; // see [R25]
        compare_value_b <= compare_b_wr ? compare_wdata : compare_buf_b;
      end else if (pwm_top) begin
        compare_value_a <= compare_buf_a; // see [R25]
        compare_value_b <= compare_buf_b;
      end
      if (capture_wr) begin
        capture_value <= capture_wdata; // see [R14]
      end
    end
  end

  // sticky flags: set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
      capture_flag <= 1'b0;
    end else begin
      overflow_flag <= set_ovf || (overflow_flag && !overflow_ack); // see [R10]
      compare_a_flag <= set_cmp_a || (compare_a_flag && !compare_a_clear); // see [R23]
      compare_b_flag <= match_b || (compare_b_flag && !compare_b_clear);
      capture_flag <= set_cap || (capture_flag && !capture_clear); // see [R4]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_a_output_latch <= 1'b0; // see [R1]
      channel_b_output_latch <= 1'b0; // see [R1]
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      channel_a_output_latch <= next_latch_a; // see [R5]
      channel_b_output_latch <= next_latch_b;
      pin_a_out <= next_pin_a;
      pin_b_out <= next_pin_b;
      pin_a_oe <= channel_a_pin_direction_bit; // see [R3]
      pin_b_oe <= channel_b_pin_direction_bit;
    end
  end

  a_reset_clears_latch: assert property (@(posedge core_clk) rst |=> // see [R1]
    !channel_a_output_latch && !channel_b_output_latch)
    else $error("latch not cleared by reset");

  a_pin_override_mux: assert property (@(posedge core_clk) disable iff (rst) // see [R2]
    (channel_a_output_action != 2'h0) |=> pin_a_out == $past(channel_a_output_latch))
    else $error("pin a not driven from latch");

  a_pin_dir_follow: assert property (@(posedge core_clk) disable iff (rst) // see [R3]
    !channel_b_pin_direction_bit ##1 !channel_b_pin_direction_bit |-> !pin_b_oe)
    else $error("pin b enabled while direction is input");

  a_no_action_hold: assert property (@(posedge core_clk) disable iff (rst) // see [R5]
    (channel_a_output_action == 2'h0) |=> $stable(channel_a_output_latch))
    else $error("latch a changed with no action");

  a_normal_wrap_ovf: assert property (@(posedge core_clk) disable iff (rst) // see [R8]
    (tick && mode_normal && count_value == 16'hFFFF && !count_wr)
    |=> count_value == 16'h0000 && overflow_flag)
    else $error("normal mode wrap or overflow wrong");

  a_ctc_clear_top: assert property (@(posedge core_clk) disable iff (rst) // see [R12]
    (tick && mode_ctc_cmp && !match_block && !count_wr && count_value == compare_value_a)
    |=> count_value == 16'h0000 && compare_a_flag)
    else $error("clear on match failed");

  a_force_keeps_count: assert property (@(posedge core_clk) disable iff (rst) // see [R23]
    (force_compare_strobe_a && !tick && !count_wr) |=> $stable(count_value))
    else $error("force disturbed the count");

  a_write_blocks_match: assert property (@(posedge core_clk) disable iff (rst) // see [R24]
    count_wr ##1 (tick && !count_wr && !compare_a_flag && !mode_pwm) |=> !compare_a_flag)
    else $error("match not blocked after count write");

  a_fast_top_ovf: assert property (@(posedge core_clk) disable iff (rst) // see [R26]
    (tick && mode_fast && at_top && !match_block && !count_wr)
    |=> overflow_flag && count_value == 16'h0000)
    else $error("fast pwm top handling wrong");

  a_toggle_on_match: assert property (@(posedge core_clk) disable iff (rst) // see [R15]
    (mode_ctc_cmp && match_a && channel_a_output_action == 2'h1)
    |=> channel_a_output_latch != $past(channel_a_output_latch))
    else $error("toggle on match missing");

  c_ctc_toggle: cover property (@(posedge core_clk) disable iff (rst)
    mode_ctc_cmp && match_a && channel_a_output_action == 2'h1);
  c_fast_pwm_top: cover property (@(posedge core_clk) disable iff (rst) pwm_top);
  c_normal_wrap: cover property (@(posedge core_clk) disable iff (rst) mode_normal && wrap);
  c_force_used: cover property (@(posedge core_clk) disable iff (rst) force_a);
endmodule

/* File: tb/tmw_pin_load.sv */
// pad model for one timer output pin with a pull resistor as load
`timescale 1ns/100ps
module tmw_pin_load #(
  parameter logic PULL = 1'b1
) (
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pad
);
  // a released pad floats to the pull level, never the last driven value
  assign pad = pin_oe ? pin_out : PULL;
endmodule

/* File: tb/test_timer16_waveform_modes.sv */
// self-checking bench for the waveform timer
`timescale 1ns/100ps
module test_timer16_waveform_modes;
  logic core_clk = 1'b0, rst = 1'b1;
  logic [2:0] clock_select = 3'h0;
  logic [3:0] waveform_select = 4'h0;
  logic [1:0] channel_a_output_action = 2'h0, channel_b_output_action = 2'h0;
  logic force_compare_strobe_a = 1'b0, force_compare_strobe_b = 1'b0, count_wr = 1'b0;
  logic compare_a_wr = 1'b0, compare_b_wr = 1'b0, capture_wr = 1'b0, overflow_ack = 1'b0;
  logic compare_a_clear = 1'b0, compare_b_clear = 1'b0, capture_clear = 1'b0;
  logic port_out_a = 1'b0, port_out_b = 1'b0;
  logic channel_a_pin_direction_bit = 1'b1, channel_b_pin_direction_bit = 1'b1;
  logic [15:0] count_wdata = 16'h0000, compare_wdata = 16'h0000, capture_wdata = 16'h0000;
  logic [15:0] count_value, pc;
  logic overflow_flag, compare_a_flag, compare_b_flag, capture_flag, pad_a, pla, plb;
  logic channel_a_output_latch, channel_b_output_latch, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic lat_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic pin_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int n_fail = 0, n_compared = 0, k, gap;

  always #5 core_clk = ~core_clk;

  tmw_timer uut (.core_clk, .rst, .clock_select, .waveform_select, .channel_a_output_action,
    .channel_b_output_action, .force_compare_strobe_a, .force_compare_strobe_b, .count_wr,
    .count_wdata, .compare_a_wr, .compare_b_wr, .compare_wdata, .capture_wr, .capture_wdata,
    .overflow_ack, .compare_a_clear, .compare_b_clear, .capture_clear, .port_out_a, .port_out_b,
    .channel_a_pin_direction_bit, .channel_b_pin_direction_bit, .count_value, .overflow_flag,
    .compare_a_flag, .compare_b_flag, .capture_flag, .channel_a_output_latch,
    .channel_b_output_latch, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe);
  tmw_pin_load load_a (.pin_out(pin_a_out), .pin_oe(pin_a_oe), .pad(pad_a));
  tmw_pin_load #(.PULL(1'b0)) load_b (.pin_out(pin_b_out), .pin_oe(pin_b_oe), .pad(plb));

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wr_count(input logic [15:0] v);
    count_wdata = v;
    pulse(count_wr);
  endtask
  task automatic wr_cmp(input logic sel_b, input logic [15:0] v);
    compare_wdata = v;
    compare_a_wr = ~sel_b;
    compare_b_wr = sel_b;
    cyc(1);
    compare_a_wr = 1'b0;
    compare_b_wr = 1'b0;
  endtask
  task automatic wait_cnt(input logic [15:0] v, input int lim);
    int i;
    for (i = 0; i < lim && count_value !== v; i++) cyc(1);
    if (count_value !== v) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, count_value, v);
      stop_test();
    end
  endtask
  task automatic wait_chg(output int n);
    logic [15:0] s;
    s = count_value;
    for (n = 1; n <= 2100; n++) begin
      cyc(1);
      if (count_value !== s) return;
    end
    n_fail++;
    $display("wrong value at %0t: got %h expected not %h", $time, count_value, s);
    stop_test();
  endtask

  initial begin
    cyc(12);
    rst = 1'b0;
    chk16(count_value, tmw_pkg::CNT_RESET);
    chk1(channel_a_output_latch, 1'b0);
    chk1(channel_b_output_latch, 1'b0);
    $display("test reset done");
    port_out_b = 1'b1;
    for (k = 0; k < 4; k++) begin
      channel_a_output_action = acts[k];
      pulse(force_compare_strobe_a);
      chk1(channel_a_output_latch, lat_exp[k]);
      chk1(compare_a_flag, 1'b0);
      cyc(1);
      chk1(pad_a, pin_exp[k]);
    end
    chk16(count_value, 16'h0000);
    chk1(capture_flag, 1'b0);
    chk1(plb, 1'b1);
    channel_a_pin_direction_bit = 1'b0;
    channel_b_pin_direction_bit = 1'b0;
    cyc(2);
    chk1(pin_a_oe, 1'b0);
    chk1(pad_a, 1'b1);
    chk1(pin_b_oe, 1'b0);
    chk1(pin_b_out, 1'b1);
    chk1(plb, 1'b0);
    $display("test force and pin done");
    wr_count(16'hFFFD);
    clock_select = tmw_pkg::CS_DIV1;
    wait_cnt(16'h0000, 10);
    chk1(overflow_flag, 1'b1);
    cyc(1);
    chk16(count_value, 16'h0001);
    pulse(overflow_ack);
    chk1(overflow_flag, 1'b0);
    wr_count(16'h1234);
    chk16(count_value, 16'h1234);
    $display("test normal done");
    for (k = 0; k < 4; k++) begin
      clock_select = 3'(k + 2);
      wait_chg(gap);
      wait_chg(gap);
      chk16(16'(gap), 16'(8 << (k == 0 ? 0 : 2 * k + 1)));
    end
    $display("test prescaler done");
    clock_select = tmw_pkg::CS_STOP;
    waveform_select = tmw_pkg::WS_CTC_CMP;
    wr_cmp(1'b0, 16'h0002);
    channel_a_output_action = tmw_pkg::ACT_TOGGLE;
    pulse(compare_a_clear);
    wr_count(16'h0000);
    clock_select = tmw_pkg::CS_DIV1;
    for (k = 0; k < 12; k++) begin
      pc = count_value;
      pla = channel_a_output_latch;
      cyc(1);
      if (pc === 16'h0002) begin
        chk16(count_value, 16'h0000);
        chk1(channel_a_output_latch, ~pla);
        chk1(compare_a_flag, 1'b1);
      end else begin
        chk16(count_value, pc + 16'h0001);
        chk1(channel_a_output_latch, pla);
      end
    end
    chk1(overflow_flag, 1'b0);
    wr_count(16'hFFFC);
    wait_cnt(16'h0000, 10);
    chk1(overflow_flag, 1'b1);
    clock_select = tmw_pkg::CS_STOP;
    wr_count(16'h0002);
    pulse(compare_a_clear);
    clock_select = tmw_pkg::CS_DIV1;
    cyc(1);
    chk16(count_value, 16'h0003);
    chk1(compare_a_flag, 1'b0);
    clock_select = tmw_pkg::CS_STOP;
    waveform_select = tmw_pkg::WS_CTC_CAP;
    capture_wdata = 16'h0003;
    pulse(capture_wr);
    wr_count(16'h0000);
    clock_select = tmw_pkg::CS_DIV1;
    wait_cnt(16'h0003, 10);
    cyc(1);
    chk16(count_value, 16'h0000);
    chk1(capture_flag, 1'b1);
    $display("test clear on match done");
    clock_select = tmw_pkg::CS_STOP;
    wr_cmp(1'b0, 16'h0014);
    cyc(1);
    wr_cmp(1'b1, 16'h000A);
    channel_a_output_action = tmw_pkg::ACT_SET;
    channel_b_output_action = tmw_pkg::ACT_CLEAR;
    waveform_select = tmw_pkg::WS_FAST_8;
    wr_count(16'h0000);
    pulse(overflow_ack);
    clock_select = tmw_pkg::CS_DIV1;
    for (k = 0; k < 600; k++) begin
      pc = count_value;
      cyc(1);
      if (pc === tmw_pkg::TOP_8BIT) begin
        chk16(count_value, 16'h0000);
        chk1(overflow_flag, 1'b1);
        chk1(channel_a_output_latch, 1'b1);
        chk1(channel_b_output_latch, 1'b0);
      end else if (pc === 16'h0014) begin
        chk1(channel_a_output_latch, 1'b0);
      end else if (pc === 16'h000A) begin
        chk1(channel_b_output_latch, 1'b1);
        chk1(compare_b_flag, 1'b1);
      end else begin
        chk16(count_value, pc + 16'h0001);
      end
      overflow_ack = (pc === tmw_pkg::TOP_8BIT);
      compare_b_clear = (pc === 16'h000A);
    end
    $display("test fast pwm done");
    clock_select = tmw_pkg::CS_STOP;
    waveform_select = tmw_pkg::WS_NORMAL;
    wr_cmp(1'b0, tmw_pkg::MIN_REG_TOP);
    waveform_select = tmw_pkg::WS_FAST_CMP;
    channel_a_output_action = tmw_pkg::ACT_TOGGLE;
    pla = channel_a_output_latch;
    pulse(force_compare_strobe_a);
    chk1(channel_a_output_latch, pla);
    pulse(compare_a_clear);
    pulse(overflow_ack);
    wr_count(16'h0000);
    clock_select = tmw_pkg::CS_DIV1;
    for (k = 0; k < 9; k++) begin
      pc = count_value;
      pla = channel_a_output_latch;
      cyc(1);
      if (pc === tmw_pkg::MIN_REG_TOP) begin
        chk16(count_value, 16'h0000);
        chk1(channel_a_output_latch, ~pla);
        chk1(overflow_flag, 1'b1);
        chk1(compare_a_flag, 1'b1);
      end else begin
        chk16(count_value, pc + 16'h0001);
        chk1(channel_a_output_latch, pla);
      end
      overflow_ack = (pc === tmw_pkg::MIN_REG_TOP);
      compare_a_clear = (pc === tmw_pkg::MIN_REG_TOP);
    end
    clock_select = tmw_pkg::CS_STOP;
    capture_wdata = 16'h0005;
    pulse(capture_wr);
    pulse(capture_clear);
    waveform_select = tmw_pkg::WS_FAST_CAP;
    wr_count(16'h0000);
    clock_select = tmw_pkg::CS_DIV1;
    wait_cnt(16'h0005, 10);
    cyc(1);
    chk16(count_value, 16'h0000);
    chk1(capture_flag, 1'b1);
    waveform_select = tmw_pkg::WS_FAST_9;
    wr_count(16'h01FD);
    wait_cnt(16'h0000, 10);
    waveform_select = tmw_pkg::WS_FAST_10;
    wr_count(16'h03FD);
    wait_cnt(16'h0000, 10);
    $display("test pwm tops done");
    clock_select = tmw_pkg::CS_STOP;
    waveform_select = tmw_pkg::WS_NORMAL;
    channel_a_output_action = tmw_pkg::ACT_SET;
    pulse(force_compare_strobe_a);
    chk1(channel_a_output_latch, 1'b1);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk1(channel_a_output_latch, 1'b0);
    chk16(count_value, tmw_pkg::CNT_RESET);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
